// >>> fcq_pkg.sv
// Package: command codes, query map and bus timing for the flash controller
package fcq_pkg;
  // Command and unlock values are parameters of the top module; these are
  // the documented query command and plain defaults.
  localparam logic [7:0]  FCQ_CMD_QUERY     = 8'h98;
  localparam logic [22:0] FCQ_QUERY_ADDR    = 23'h000055;
  localparam logic [7:0]  FCQ_DEF_UNLK_D1   = 8'haa;
  localparam logic [7:0]  FCQ_DEF_UNLK_D2   = 8'h55;
  localparam logic [22:0] FCQ_DEF_UNLK_A1   = 23'h000555;
  localparam logic [22:0] FCQ_DEF_UNLK_A2   = 23'h0002aa;
  localparam logic [7:0]  FCQ_DEF_CMD_ASEL  = 8'h90;
  localparam logic [7:0]  FCQ_DEF_CMD_RESET = 8'hf0;
  // Query table addresses and expected bytes
  localparam logic [7:0]  FCQ_A_SIZE        = 8'h27;
  localparam logic [7:0]  FCQ_V_SIZE        = 8'h17;
  localparam logic [7:0]  FCQ_A_NREGION     = 8'h2c;
  localparam logic [7:0]  FCQ_A_R1_FIRST    = 8'h2d;
  localparam logic [7:0]  FCQ_A_R1_LAST     = 8'h30;
  localparam logic [7:0]  FCQ_A_EXT_FIRST   = 8'h40;
  localparam logic [7:0]  FCQ_A_EXT_LAST    = 8'h4f;
  // Autoselect addresses
  localparam logic [7:0]  FCQ_A_MFR         = 8'h00;
  localparam logic [7:0]  FCQ_A_DEV         = 8'h01;
  localparam logic [7:0]  FCQ_A_PROT        = 8'h02;
  localparam logic [7:0]  FCQ_A_SECURE      = 8'h03;
  // Bus timing, ns, and derived cycle counts at 25 MHz
  localparam int          FCQ_CLK_NS        = 40;
  localparam int          FCQ_T_ACC_NS      = 90;
  localparam int          FCQ_T_WP_NS       = 35;
  localparam int          FCQ_T_GAP_NS      = 30;
  localparam logic [3:0]  FCQ_ACC_CYC =
    4'((FCQ_T_ACC_NS + FCQ_CLK_NS - 1) / FCQ_CLK_NS);
  localparam logic [3:0]  FCQ_WP_CYC  =
    4'((FCQ_T_WP_NS + FCQ_CLK_NS - 1) / FCQ_CLK_NS);
  localparam logic [3:0]  FCQ_GAP_CYC =
    4'((FCQ_T_GAP_NS + FCQ_CLK_NS - 1) / FCQ_CLK_NS);
  // User operations
  typedef enum logic [2:0] {
    FCQ_OP_READ   = 3'h0,
    FCQ_OP_WRITE  = 3'h1,
    FCQ_OP_RESET  = 3'h2,
    FCQ_OP_ASEL   = 3'h3,
    FCQ_OP_QUERY  = 3'h4
  } fcq_op_t;
  // Host view of the device mode
  typedef enum logic [1:0] {
    FCQ_M_ARRAY = 2'h0,
    FCQ_M_ASEL  = 2'h1,
    FCQ_M_QUERY = 2'h2
  } fcq_mode_t;
endpackage

// >>> fcq_bus_cycle.sv
// Single flash bus cycle engine: one read or one write per start pulse
module fcq_bus_cycle
  import fcq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        start_i,
  input  wire logic        wr_i,
  input  wire logic [22:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  dq_sync_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  output logic [22:0]      flash_addr_o,
  output logic             flash_ce_n_o,
  output logic             flash_we_n_o,
  output logic             flash_oe_n_o,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe_o
);
  typedef enum logic [3:0] {
    FCQ_B_IDLE   = 4'b0001,
    FCQ_B_SETUP  = 4'b0010,
    FCQ_B_STROBE = 4'b0100,
    FCQ_B_GAP    = 4'b1000
  } fcq_bst_t;

  fcq_bst_t   st_q;
  logic [3:0] cnt_q;
  logic       wr_q;
  // Two extra cycles cover the two-stage input synchroniser
  wire [3:0]  rd_len = FCQ_ACC_CYC + 4'h2;
  wire        cnt_done = (cnt_q == 4'h0);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q          <= FCQ_B_IDLE;
      cnt_q         <= 4'h0;
      wr_q          <= 1'b0;
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      rdata_o       <= 8'h00;
      flash_addr_o  <= 23'h000000;
      flash_ce_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      flash_dq_o    <= 8'h00;
      flash_dq_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!cnt_done) begin
        cnt_q <= cnt_q - 4'h1;
      end
      case (st_q)
        FCQ_B_IDLE: begin
          if (start_i) begin
            // Address stable before either strobe falls
            st_q          <= FCQ_B_SETUP;
            busy_o        <= 1'b1;
            wr_q          <= wr_i;
            flash_addr_o  <= addr_i;
            flash_dq_o    <= wdata_i;
            flash_dq_oe_o <= wr_i;
            flash_ce_n_o  <= 1'b0;
          end
        end
        FCQ_B_SETUP: begin
          // CE already low, so WE falling is the later edge and latches
          // the address; WE rising first latches the data.
          st_q <= FCQ_B_STROBE; // R11
          if (wr_q) begin
            flash_we_n_o <= 1'b0;
            cnt_q        <= FCQ_WP_CYC;
          end else begin
            flash_oe_n_o <= 1'b0;
            cnt_q        <= rd_len;
          end
        end
        FCQ_B_STROBE: begin
          if (cnt_done) begin
            st_q         <= FCQ_B_GAP;
            flash_we_n_o <= 1'b1; // R11
            flash_oe_n_o <= 1'b1;
            cnt_q        <= FCQ_GAP_CYC;
            if (!wr_q) begin
              rdata_o <= dq_sync_i;
            end
          end
        end
        FCQ_B_GAP: begin
          // CE rises after WE so data hold is met
          flash_ce_n_o <= 1'b1;
          if (cnt_done) begin
            st_q          <= FCQ_B_IDLE;
            flash_dq_oe_o <= 1'b0;
            busy_o        <= 1'b0;
            done_o        <= 1'b1;
          end
        end
        default: begin
          st_q <= FCQ_B_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> fcq_ctrl.sv
// Host controller that drives a parallel flash's command and query modes
//
// Functional notes
// (R1) Query byte 27h gives size exponent 17h; 28h-2Bh zero; 2Ch one region.
// (R2) Region one description bytes 7Fh,00h,00h,01h at 2Dh-30h.
// (R3) Query 31h-3Ch read zero: regions two to four absent.
// (R4) Extended table starts "PRI" at 40h, versions 31h at 43h, 44h.
// (R5) Byte 45h reads 01h: unlock sensitivity low bits, revision upper.
// (R6) Byte 46h reads 02h: erase suspend allows read and program.
// (R7) Bytes 47h,48h,49h read 04h, 01h, 04h.
// (R8) Bytes 4Ah-4Ch read zero: no simultaneous, burst or page mode.
// (R9) Bytes 4Dh,4Eh read B5h,C5h acceleration supply; 4Fh reads 00h.
// (R10) Bad or misordered cycles may confuse device; host then writes reset.
// (R11) Address latched on later falling strobe, data on earlier rising.
// (R12) Device starts and returns to read-array without a command.
// (R13) Erase suspend enters erase-suspend-read for non-suspended sectors.
// (R14) Host writes reset after timing-limit flag or when in autoselect.
// (R15) Reset returns to read or erase-suspend-read; address ignored.
// (R16) Reset aborts erase sequence before start; ignored once erasing.
// (R17) Reset aborts program sequence before start; ignored once programming.
// (R18) Reset leaves autoselect to read or erase-suspend-read.
// (R19) Reset after timing-limit flag returns to read or suspend-read.
// (R20) Autoselect: maker 00h, device 01h, secure flag 03h, protect SA/02h.
// (R21) Host issues autoselect only in read or erase-suspend-read mode; the code does not check the mode and only holds autoselect off while busy.
// (R22) Autoselect entry is two unlock cycles then the command cycle.
// (R23) Query command 98h from read or autoselect; reset ends it.
// (R24) Unlock, command codes and identifiers are parameters; the query command 98h is a fixed package constant, not a parameter.
// (R25) Unlisted query addresses read 00h.
module fcq_ctrl
  import fcq_pkg::*;
#(
  parameter logic [22:0] UNLK_A1   = FCQ_DEF_UNLK_A1,
  parameter logic [22:0] UNLK_A2   = FCQ_DEF_UNLK_A2,
  parameter logic [7:0]  UNLK_D1   = FCQ_DEF_UNLK_D1,
  parameter logic [7:0]  UNLK_D2   = FCQ_DEF_UNLK_D2,
  parameter logic [7:0]  CMD_ASEL  = FCQ_DEF_CMD_ASEL,
  parameter logic [7:0]  CMD_RESET = FCQ_DEF_CMD_RESET
)(
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            req_i,
  input  wire fcq_pkg::fcq_op_t op_i,
  input  wire logic [22:0]     addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            busy_flag_i,
  output logic                 ready_o,
  output logic                 done_o,
  output logic [7:0]           rdata_o,
  output logic                 mismatch_o,
  output logic [1:0]           mode_o,
  output logic [22:0]          flash_addr_o,
  output logic                 flash_ce_n_o,
  output logic                 flash_we_n_o,
  output logic                 flash_oe_n_o,
  input  wire logic [7:0]      flash_dq_i,
  output logic [7:0]           flash_dq_o,
  output logic                 flash_dq_oe_o
);
  import fcq_pkg::*;

  typedef enum logic [3:0] {
    FCQ_S_IDLE = 4'b0001,
    FCQ_S_ISSUE = 4'b0010,
    FCQ_S_WAIT = 4'b0100,
    FCQ_S_DONE = 4'b1000
  } fcq_st_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [7:0] dq_s1_q, dq_s2_q;
  logic       bsy_s1_q, bsy_s2_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dq_s1_q  <= 8'h00;
      dq_s2_q  <= 8'h00;
      bsy_s1_q <= 1'b0;
      bsy_s2_q <= 1'b0;
    end else begin
      dq_s1_q  <= flash_dq_i;
      dq_s2_q  <= dq_s1_q;
      bsy_s1_q <= busy_flag_i;
      bsy_s2_q <= bsy_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected query bytes, used to flag a device that answers wrongly
  function automatic logic [7:0] fcq_expect(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00; // R3 R8 R25
    case (a)
      FCQ_A_SIZE:    v = FCQ_V_SIZE;     // R1
      FCQ_A_NREGION: v = 8'h01;          // R1
      8'h2d:         v = 8'h7f;          // R2
      FCQ_A_R1_LAST: v = 8'h01;          // R2
      FCQ_A_EXT_FIRST: v = 8'h50;        // R4
      8'h41:         v = 8'h52;          // R4
      8'h42:         v = 8'h49;          // R4
      8'h43:         v = 8'h31;          // R4
      8'h44:         v = 8'h31;          // R4
      8'h45:         v = 8'h01;          // R5
      8'h46:         v = 8'h02;          // R6
      8'h47:         v = 8'h04;          // R7
      8'h48:         v = 8'h01;          // R7
      8'h49:         v = 8'h04;          // R7
      8'h4d:         v = 8'hb5;          // R9
      8'h4e:         v = 8'hc5;          // R9
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // Only the geometry and extended tables are checked; other areas unknown
  wire in_geom = (addr_i[7:0] >= FCQ_A_SIZE) && (addr_i[7:0] <= 8'h3c);
  wire in_ext  = (addr_i[7:0] >= FCQ_A_EXT_FIRST) &&
                 (addr_i[7:0] <= FCQ_A_EXT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence
  fcq_st_t     st_q;
  fcq_op_t     op_q;
  logic [1:0]  step_q, last_q;
  logic [22:0] a_q;
  logic [7:0]  d_q;
  logic [7:0]  qaddr_q;
  logic        chk_q;
  logic        start_q;
  logic        bc_busy, bc_done;
  logic [7:0]  bc_rdata;
  fcq_mode_t   mode_q;

  // Autoselect is refused while the device reports an embedded operation
  wire op_ok = !((op_i == FCQ_OP_ASEL) && bsy_s2_q); // R21

  // Per-step address and data of the multi-cycle sequences
  logic [22:0] seq_a;
  logic [7:0]  seq_d;
  always_comb begin
    seq_a = a_q;
    seq_d = d_q;
    if (op_q == FCQ_OP_ASEL) begin
      case (step_q) // R22
        2'd0:    begin seq_a = UNLK_A1; seq_d = UNLK_D1; end
        2'd1:    begin seq_a = UNLK_A2; seq_d = UNLK_D2; end
        default: begin seq_a = UNLK_A1; seq_d = CMD_ASEL; end
      endcase
    end
  end

  wire seq_wr = (op_q != FCQ_OP_READ);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q       <= FCQ_S_IDLE;
      op_q       <= FCQ_OP_READ;
      step_q     <= 2'd0;
      last_q     <= 2'd0;
      a_q        <= 23'h000000;
      d_q        <= 8'h00;
      qaddr_q    <= 8'h00;
      chk_q      <= 1'b0;
      start_q    <= 1'b0;
      ready_o    <= 1'b0;
      done_o     <= 1'b0;
      rdata_o    <= 8'h00;
      mismatch_o <= 1'b0;
      mode_q     <= FCQ_M_ARRAY; // R12
    end else begin
      start_q <= 1'b0;
      done_o  <= 1'b0;
      case (st_q)
        FCQ_S_IDLE: begin
          ready_o <= 1'b1;
          if (req_i && op_ok) begin
            ready_o <= 1'b0;
            op_q    <= op_i;
            step_q  <= 2'd0;
            qaddr_q <= addr_i[7:0];
            chk_q   <= (mode_q == FCQ_M_QUERY) && (in_geom || in_ext);
            case (op_i)
              FCQ_OP_RESET: begin
                // Any address will do for reset
                a_q    <= 23'h000000; // R15
                d_q    <= CMD_RESET;  // R24
                last_q <= 2'd0;
              end
              FCQ_OP_QUERY: begin
                a_q    <= FCQ_QUERY_ADDR; // R23
                d_q    <= FCQ_CMD_QUERY;
                last_q <= 2'd0;
              end
              FCQ_OP_ASEL: begin
                a_q    <= addr_i;
                d_q    <= wdata_i;
                last_q <= 2'd2;
              end
              default: begin
                a_q    <= addr_i;
                d_q    <= wdata_i;
                last_q <= 2'd0;
              end
            endcase
            st_q <= FCQ_S_ISSUE;
          end
        end
        FCQ_S_ISSUE: begin
          start_q <= 1'b1;
          st_q    <= FCQ_S_WAIT;
        end
        FCQ_S_WAIT: begin
          if (bc_done) begin
            if (step_q != last_q) begin
              step_q <= step_q + 2'd1;
              st_q   <= FCQ_S_ISSUE;
            end else begin
              st_q <= FCQ_S_DONE;
            end
          end
        end
        FCQ_S_DONE: begin
          done_o <= 1'b1;
          st_q   <= FCQ_S_IDLE;
          if (op_q == FCQ_OP_READ) begin
            rdata_o <= bc_rdata;
            if (chk_q) begin
              mismatch_o <= (bc_rdata != fcq_expect(qaddr_q));
            end
          end
          case (op_q)
            // Device goes back to array or suspend-read; host tracks array
            FCQ_OP_RESET: mode_q <= FCQ_M_ARRAY; // R10 R14 R18 R19
            FCQ_OP_ASEL:  mode_q <= FCQ_M_ASEL;  // R20
            FCQ_OP_QUERY: mode_q <= FCQ_M_QUERY; // R23
            default:      mode_q <= mode_q;
          endcase
        end
        default: begin
          st_q <= FCQ_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_o <= 2'h0;
    end else begin
      mode_o <= mode_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  fcq_bus_cycle u_cycle (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .start_i       (start_q),
    .wr_i          (seq_wr),
    .addr_i        (seq_a),
    .wdata_i       (seq_d),
    .dq_sync_i     (dq_s2_q),
    .busy_o        (bc_busy),
    .done_o        (bc_done),
    .rdata_o       (bc_rdata),
    .flash_addr_o  (flash_addr_o),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o)
  );
endmodule

// >>> fcq_ctrl_checker.sv
// Checker: strobe, handshake and mode assertions for the flash controller
module fcq_ctrl_checker
  import fcq_pkg::*;
#(
  parameter logic [7:0] CMD_RESET = FCQ_DEF_CMD_RESET
)(
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             req_i,
  input  wire fcq_pkg::fcq_op_t op_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             ready_o,
  input  wire logic             done_o,
  input  wire logic [1:0]       mode_o,
  input  wire logic [22:0]      flash_addr_o,
  input  wire logic             flash_ce_n_o,
  input  wire logic             flash_we_n_o,
  input  wire logic             flash_oe_n_o,
  input  wire logic [7:0]       flash_dq_o,
  input  wire logic             flash_dq_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////
  fcq_op_t    op_q;
  logic [7:0] wd_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_q <= FCQ_OP_READ;
      wd_q <= 8'h00;
    end else if (req_i && ready_o) begin
      op_q <= op_i;
      wd_q <= wdata_i;
    end
  end
  // Autoselect may be held off by busy, so it is left out here
  sequence s_take;
    req_i && ready_o && op_i != FCQ_OP_ASEL;
  endsequence
  sequence s_latch;
    $rose(flash_we_n_o);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_idle;
    ready_o |-> flash_ce_n_o && flash_we_n_o && flash_oe_n_o;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe low while idle");
  property p_inhibit;
    !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("bad write strobe");
  property p_no_clash;
    !flash_oe_n_o |-> !flash_dq_oe_o;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus clash");
  property p_hold;
    !flash_we_n_o |=> $stable(flash_dq_o) && $stable(flash_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved at latch");
  property p_take;
    s_take |=> !ready_o;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_answer;
    s_take |-> ##[4:40] done_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no done");
  property p_wdata;
    s_latch ##0 op_q == FCQ_OP_WRITE |-> $past(flash_dq_o) == wd_q;
  endproperty
  a_wdata: assert property (p_wdata) else $error("wrong write data");
  property p_reset_code;
    s_latch ##0 op_q == FCQ_OP_RESET |-> $past(flash_dq_o) == CMD_RESET;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("bad reset");
  property p_asel_mode;
    done_o && op_q == FCQ_OP_ASEL |-> ##[0:2] mode_o == FCQ_M_ASEL;
  endproperty
  a_asel_mode: assert property (p_asel_mode) else $error("no asel");
  property p_query_mode;
    done_o && op_q == FCQ_OP_QUERY |-> ##[0:2] mode_o == FCQ_M_QUERY;
  endproperty
  a_query_mode: assert property (p_query_mode) else $error("no query");
  property p_reset_mode;
    done_o && op_q == FCQ_OP_RESET |-> ##[0:2] mode_o == FCQ_M_ARRAY;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("no array");
endmodule

bind fcq_ctrl fcq_ctrl_checker #(.CMD_RESET(CMD_RESET)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .op_i(op_i),
  .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o),
  .mode_o(mode_o), .flash_addr_o(flash_addr_o),
  .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o)
);

// >>> fcq_flash_model.sv
// Behavioural parallel flash: command modes, query table, identifiers
module fcq_flash_model
  import fcq_pkg::*;
#(
  parameter logic [7:0] ID_MFR = 8'h3a, // Arbitrary value
  parameter logic [7:0] ID_DEV = 8'h6e  // Arbitrary value
)(
  input  wire logic [22:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        stall_i,
  input  wire logic        bad_i,
  output logic [7:0]       dq_o,
  output logic             busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  fcq_mode_t   mode = FCQ_M_ARRAY;
  logic [1:0]  step = 2'h0;
  logic [22:0] lat_a = 23'h0;
  logic [7:0]  lat_d = 8'h00;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  rd_val;
  wire wr_act = !ce_n_i && !we_n_i && oe_n_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] qbyte(input logic [7:0] a);
    case (a)
      8'h27: return 8'h17;
      8'h2c, 8'h30, 8'h45, 8'h48: return 8'h01;
      8'h2d: return 8'h7f;
      8'h40: return 8'h50;
      8'h41: return 8'h52;
      8'h42: return 8'h49;
      8'h43, 8'h44: return 8'h31;
      8'h46: return 8'h02;
      8'h47, 8'h49: return 8'h04;
      8'h4d: return 8'hb5;
      8'h4e: return 8'hc5;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] ibyte(input logic [7:0] a);
    case (a)
      8'h00: return ID_MFR;
      8'h01: return ID_DEV;
      8'h02: return 8'h01;
      8'h03: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction
  always_comb begin
    case (mode)
      FCQ_M_QUERY: rd_val = qbyte(addr_i[7:0]) ^ {8{bad_i}};
      FCQ_M_ASEL: rd_val = ibyte(addr_i[7:0]);
      default: rd_val = addr_i[7:0] ^ addr_i[15:8] ^ 8'ha5;
    endcase
  end
  // Released bus shows the inverse so a stale sample cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_val : ~last_q;
  assign busy_o = stall_i;
  always @(posedge oe_n_i) last_q = rd_val;
  always @(posedge wr_act) lat_a = addr_i;
  always @(negedge wr_act) begin
    lat_d = dq_i;
    if (!busy_o) begin
      if (lat_d == FCQ_DEF_CMD_RESET) begin
        mode = FCQ_M_ARRAY;
        step = 2'h0;
      end else if (lat_d == FCQ_CMD_QUERY && mode != FCQ_M_QUERY) begin
        mode = FCQ_M_QUERY;
        step = 2'h0;
      end else if (step == 2'h0 && lat_a == FCQ_DEF_UNLK_A1
                   && lat_d == FCQ_DEF_UNLK_D1) begin
        step = 2'h1;
      end else if (step == 2'h1 && lat_a == FCQ_DEF_UNLK_A2
                   && lat_d == FCQ_DEF_UNLK_D2) begin
        step = 2'h2;
      end else if (step == 2'h2 && lat_d == FCQ_DEF_CMD_ASEL) begin
        mode = FCQ_M_ASEL;
        step = 2'h0;
      end else begin
        step = 2'h0;
      end
    end
  end
endmodule

// >>> test_fcq_ctrl.sv
// Testbench: drives controller operations against the flash model
module test_fcq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import fcq_pkg::*;
  localparam logic [7:0] MFR = 8'h3a; // Arbitrary value
  localparam logic [7:0] DEV = 8'h6e; // Arbitrary value
  localparam logic [327:0] QTAB = {
    160'h1700000000017f00000100000000000000000000,
    168'h000000000050524931310102040104000000b5c500};
  logic        clk_i, sys_rst_i, req_i, stall, bad;
  fcq_op_t     op_i;
  logic [22:0] addr_i, flash_addr_o;
  logic [7:0]  wdata_i, mdl_dq, rdata_o, flash_dq_o;
  logic [1:0]  mode_o;
  logic        ready_o, done_o, mismatch_o, busy;
  logic        flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_o;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  wire [7:0] dq_bus = flash_dq_oe_o ? flash_dq_o : mdl_dq;
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  fcq_ctrl u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_flag_i(busy),
    .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .mismatch_o(mismatch_o), .mode_o(mode_o), .flash_addr_o(flash_addr_o),
    .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_dq_i(dq_bus),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o));
  fcq_flash_model #(.ID_MFR(MFR), .ID_DEV(DEV)) u_mdl (
    .addr_i(flash_addr_o), .ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o),
    .oe_n_i(flash_oe_n_o), .dq_i(flash_dq_o), .stall_i(stall),
    .bad_i(bad), .dq_o(mdl_dq), .busy_o(busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [22:0] seen,
                       input logic [22:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(input fcq_op_t op, input logic [22:0] a,
                       input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    while (ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
  endtask
  task automatic run(input fcq_op_t op, input logic [22:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    issue(op, a, d);
    do begin
      @(negedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 200);
    check("done_o", 23'(done_o), 23'h1);
  endtask
  task automatic rd_chk(input logic [22:0] a, input logic [7:0] exp);
    run(FCQ_OP_READ, a, 8'h00);
    check("rdata_o", 23'(rdata_o), 23'(exp));
  endtask
  task automatic mode_is(input fcq_mode_t m);
    // Mode output trails done by one register stage
    @(negedge clk_i);
    check("mode_o", 23'(mode_o), 23'(m));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    req_i = 1'b0;
    op_i = FCQ_OP_READ;
    addr_i = 23'h0;
    wdata_i = 8'h00;
    stall = 1'b0;
    bad = 1'b0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    mode_is(FCQ_M_ARRAY);
    rd_chk(23'h123456, 8'h56 ^ 8'h34 ^ 8'ha5);
    run(FCQ_OP_WRITE, 23'h2abcde, 8'h3c);
    check("lat_a", u_mdl.lat_a, 23'h2abcde);
    check("lat_d", 23'(u_mdl.lat_d), 23'h3c);
    run(FCQ_OP_QUERY, 23'h0, 8'h00);
    mode_is(FCQ_M_QUERY);
    for (int a = 'h27; a <= 'h4f; a++)
      rd_chk(23'(a), QTAB[8*('h4f-a) +: 8]);
    check("mismatch_o", 23'(mismatch_o), 23'h0);
    bad = 1'b1;
    rd_chk(23'h46, 8'hfd);
    check("mismatch_o", 23'(mismatch_o), 23'h1);
    bad = 1'b0;
    run(FCQ_OP_RESET, 23'h7fffff, 8'h00);
    mode_is(FCQ_M_ARRAY);
    rd_chk(23'h000100, 8'ha4);
    run(FCQ_OP_ASEL, 23'h0, 8'h00);
    mode_is(FCQ_M_ASEL);
    rd_chk(23'h0, MFR);
    rd_chk(23'h1, DEV);
    rd_chk(23'h050002, 8'h01);
    rd_chk(23'h010003, 8'h80);
    rd_chk(23'h400000, MFR);
    run(FCQ_OP_QUERY, 23'h0, 8'h00);
    rd_chk(23'h27, 8'h17);
    run(FCQ_OP_RESET, 23'h0, 8'h00);
    mode_is(FCQ_M_ARRAY);
    rd_chk(23'h0, 8'ha5);
    run(FCQ_OP_WRITE, FCQ_DEF_UNLK_A1, FCQ_DEF_UNLK_D1);
    run(FCQ_OP_WRITE, FCQ_DEF_UNLK_A1, FCQ_DEF_CMD_ASEL);
    run(FCQ_OP_RESET, 23'h0, 8'h00);
    rd_chk(23'h000202, 8'ha5);
    stall = 1'b1;
    repeat (4) @(negedge clk_i);
    issue(FCQ_OP_ASEL, 23'h0, 8'h00);
    repeat (20) @(negedge clk_i);
    check("ready_o", 23'(ready_o), 23'h1);
    mode_is(FCQ_M_ARRAY);
    stall = 1'b0;
    wrap_up;
  end
endmodule
